// *** hdl/e3lapd_defines.vh ***
// constants for the e3 path maintenance message transmitter
`ifndef E3LAPD_DEFINES_VH
`define E3LAPD_DEFINES_VH
`define E3L_ADDR_OPMODE      16'h1100
`define E3L_ADDR_TXE3_CFG    16'h1130
`define E3L_ADDR_TXMSG_CFG   16'h1133
`define E3L_ADDR_TXMSG_BUF   16'h11b0
`define E3L_OPMODE_RST       8'h00
`define E3L_TXE3_RST         8'h00
`define E3L_TXMSG_RST        8'h00
`define E3L_TXE3_MASK        8'h17
`define E3L_TXMSG_MASK       8'h8b
`define E3L_BIT_NR_SEL       4
`define E3L_BIT_ENABLE       0
`define E3L_BIT_LEN82        1
`define E3L_BIT_AUTO         3
`define E3L_BIT_ANYLEN       7
`define E3L_BIT_BUSY         5
`define E3L_FLAG             8'h7e
`define E3L_HDR_BYTES        7'h04
`define E3L_LEN_STD          7'h4c
`define E3L_LEN_ITU          7'h52
`define E3L_BUF_DEPTH        90
`define E3L_CRC_POLY         16'h1021
`define E3L_CRC_INIT         16'hffff
`define E3L_STUFF_RUN        3'h5
`define E3L_SECOND_NS        1000000000
`define E3L_CLK_PERIOD_NS    10
`define E3L_FIFO_DEPTH       8
`endif

// *** hdl/e3lapd_fifo.v ***
// small synchronous fifo carrying outbound octets to the overhead slot
`timescale 1ns/1ps
module e3lapd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             core_clk,  // clock
    input  wire             reset_n,   // async reset, active low
    input  wire             in_valid,  // write request
    output wire             in_ready,  // not full
    input  wire [WIDTH-1:0] in_data,   // write data
    output wire             out_valid, // not empty
    input  wire             out_ready, // read request
    output wire [WIDTH-1:0] out_data   // head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// *** hdl/e3lapd_tx.v ***
// transmit controller for path maintenance messages in the e3 nr or gc byte
// How it works
// - header control byte is 0x03, so frames are unnumbered
// - payload sent is exactly the bytes software stored: 76, 82 or any count
// - a 16-bit check over header and payload uses x16+x12+x5+1
// - check value follows payload, high byte first, then closing flag
// - both fixed 76/82 byte and variable length messages up to 86 bytes
// - channel select bit 4: 1 carries bytes in nr, 0 in gc
// - one octet of the stuffed bit stream goes into the selected byte of every frame while enabled
// - enable bit 0 starts the transmitter; clearing it stops messages
// - while enabled and not sending, continuous 0x7e flags are sent
// - a 90-byte store holds flag, header, payload of the next message
// - 0x7e flags open and close every message frame
// - length bit 1: 1 means 82 payload bytes, 0 means 76
// - auto retransmit bit 3 resends the stored message every second
`timescale 1ns/1ps
`include "e3lapd_defines.vh"
module e3lapd_tx #(
    parameter SEC_CYCLES = `E3L_SECOND_NS / `E3L_CLK_PERIOD_NS
) (
    input  wire       core_clk,    // 100 mhz clock
    input  wire       reset_n,     // async reset, active low
    input  wire [15:0] cpu_addr,   // register address
    input  wire       cpu_wr,      // write strobe, one cycle
    input  wire       cpu_rd,      // read strobe, one cycle
    input  wire [7:0] cpu_wdata,   // write data
    output reg  [7:0] cpu_rdata_q, // read data, valid cycle after cpu_rd
    input  wire       frame_slot,  // pulse: overhead byte slot of a frame
    output reg        nr_ins_q,    // pulse: oh_byte_q goes into nr byte
    output reg        gc_ins_q,    // pulse: oh_byte_q goes into gc byte
    output reg  [7:0] oh_byte_q    // byte for the overhead position
);
    localparam S_IDLE = 4'b0001;
    localparam S_OPEN = 4'b0010;
    localparam S_DATA = 4'b0100;
    localparam S_FCS  = 4'b1000;

    function [15:0] crc_step;
        input [15:0] crc;
        input        bit_in;
        begin
            crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ bit_in) ? `E3L_CRC_POLY : 16'h0000);
        end
    endfunction

    reg [7:0]  opmode_q;
    reg [7:0]  txe3_q;
    reg [7:0]  txmsg_q;
    reg [7:0]  buf_mem [0:`E3L_BUF_DEPTH-1];
    reg [6:0]  wr_cnt_q;
    reg [6:0]  last_q;
    reg        has_msg_q;
    reg        pend_q;
    reg [31:0] sec_cnt_q;
    reg [3:0]  state_q;
    reg [7:0]  cur_q;
    reg [2:0]  bit_q;
    reg [6:0]  idx_q;
    reg [2:0]  ones_q;
    reg [15:0] crc_q;
    reg        fcs_lo_q;
    reg [7:0]  asm_q;
    reg [2:0]  asm_cnt_q;
    reg        asm_full_q;

    wire       enable  = txmsg_q[`E3L_BIT_ENABLE];
    wire       anylen  = txmsg_q[`E3L_BIT_ANYLEN];
    wire [6:0] std_len = txmsg_q[`E3L_BIT_LEN82] ? `E3L_LEN_ITU : `E3L_LEN_STD;
    wire [6:0] std_tot = std_len + `E3L_HDR_BYTES;
    wire       wr_buf  = cpu_wr && (cpu_addr == `E3L_ADDR_TXMSG_BUF);
    wire       wr_msg  = cpu_wr && (cpu_addr == `E3L_ADDR_TXMSG_CFG);
    wire       sec_tick = (sec_cnt_q == SEC_CYCLES - 1);
    wire       busy    = !state_q[0];
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire       stuffed = state_q[2] || state_q[3];
    // a run of five ones left by the check value is still broken before the closing flag
    wire       stuff_now = (ones_q == `E3L_STUFF_RUN);
    wire       tx_bit  = stuff_now ? 1'b0 : cur_q[bit_q];
    wire [15:0] crc_next = crc_step(crc_q, tx_bit);
    wire       step    = !asm_full_q && enable;
    wire       byte_end = step && !stuff_now && (bit_q == 3'h7);
    wire       fill_done = wr_buf && !anylen && (wr_cnt_q + 7'h01 == std_tot);
    wire       arm_en  = wr_msg && cpu_wdata[`E3L_BIT_ENABLE] && (wr_cnt_q >= `E3L_HDR_BYTES);
    wire       start_req = fill_done || arm_en
                           || (txmsg_q[`E3L_BIT_AUTO] && sec_tick && has_msg_q);
    wire       take    = byte_end && state_q[0] && pend_q;

    // register port and message store
    always @(posedge core_clk) begin
        if (wr_buf && (wr_cnt_q < `E3L_BUF_DEPTH)) begin
            buf_mem[wr_cnt_q] <= cpu_wdata;
        end
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            opmode_q    <= `E3L_OPMODE_RST;
            txe3_q      <= `E3L_TXE3_RST;
            txmsg_q     <= `E3L_TXMSG_RST;
            cpu_rdata_q <= 8'h00;
            wr_cnt_q    <= 7'h00;
            last_q      <= 7'h00;
            has_msg_q   <= 1'b0;
            pend_q      <= 1'b0;
            sec_cnt_q   <= 32'h0000_0000;
        end else begin
            if (cpu_wr && cpu_addr == `E3L_ADDR_OPMODE) begin
                opmode_q <= cpu_wdata;
            end
            if (cpu_wr && cpu_addr == `E3L_ADDR_TXE3_CFG) begin
                txe3_q <= cpu_wdata & `E3L_TXE3_MASK;
            end
            if (wr_msg) begin
                txmsg_q <= cpu_wdata & `E3L_TXMSG_MASK;
            end
            if (cpu_rd) begin
                case (cpu_addr)
                    `E3L_ADDR_OPMODE:    cpu_rdata_q <= opmode_q;
                    `E3L_ADDR_TXE3_CFG:  cpu_rdata_q <= txe3_q;
                    `E3L_ADDR_TXMSG_CFG: cpu_rdata_q <= txmsg_q | ({7'h00, busy} << `E3L_BIT_BUSY);
                    default:             cpu_rdata_q <= 8'h00;
                endcase
            end
            sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
            if (take) begin
                // length is frozen for a freshly stored message; a repeat keeps it
                if (wr_cnt_q != 7'h00) begin
                    last_q <= anylen ? wr_cnt_q - 7'h01 : std_tot - 7'h01;
                end
                has_msg_q <= 1'b1;
                wr_cnt_q  <= 7'h00;
            end else if (wr_buf && (wr_cnt_q < `E3L_BUF_DEPTH)) begin
                wr_cnt_q <= wr_cnt_q + 7'h01;
            end
            if (start_req) begin
                pend_q <= 1'b1;
            end else if (take || !enable) begin
                pend_q <= 1'b0;
            end
        end
    end

    // bit engine: flags, message bytes, check value
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= S_IDLE;
            cur_q    <= `E3L_FLAG;
            bit_q    <= 3'h0;
            idx_q    <= 7'h00;
            ones_q   <= 3'h0;
            crc_q    <= `E3L_CRC_INIT;
            fcs_lo_q <= 1'b0;
        end else if (!enable) begin
            state_q  <= S_IDLE;
            cur_q    <= `E3L_FLAG;
            bit_q    <= 3'h0;
            ones_q   <= 3'h0;
        end else if (step) begin
            if (stuff_now) begin
                ones_q <= 3'h0;
            end else begin
                ones_q <= (stuffed && tx_bit) ? ones_q + 3'h1 : 3'h0;
                if (state_q[2]) begin
                    crc_q <= crc_next;
                end
                bit_q <= bit_q + 3'h1;
            end
            if (byte_end) begin
                case (state_q)
                    S_IDLE: begin
                        if (pend_q) begin
                            state_q <= S_OPEN;
                            cur_q   <= buf_mem[0];
                        end else begin
                            cur_q   <= `E3L_FLAG;
                        end
                    end
                    S_OPEN: begin
                        state_q <= S_DATA;
                        idx_q   <= 7'h01;
                        cur_q   <= buf_mem[1];
                        crc_q   <= `E3L_CRC_INIT;
                    end
                    S_DATA: begin
                        if (idx_q == last_q) begin
                            state_q  <= S_FCS;
                            fcs_lo_q <= 1'b0;
                            cur_q    <= ~crc_next[15:8];
                        end else begin
                            idx_q <= idx_q + 7'h01;
                            cur_q <= buf_mem[idx_q + 7'h01];
                        end
                    end
                    S_FCS: begin
                        if (fcs_lo_q) begin
                            state_q <= S_IDLE;
                            cur_q   <= `E3L_FLAG;
                        end else begin
                            fcs_lo_q <= 1'b1;
                            cur_q    <= ~crc_q[7:0];
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                        cur_q   <= `E3L_FLAG;
                    end
                endcase
            end
        end
    end

    // regroup the stuffed bit stream into octets, lsb first
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            asm_q      <= 8'h00;
            asm_cnt_q  <= 3'h0;
            asm_full_q <= 1'b0;
        end else if (asm_full_q) begin
            if (fifo_in_ready) begin
                asm_full_q <= 1'b0;
            end
        end else if (step) begin
            asm_q     <= {tx_bit, asm_q[7:1]};
            asm_cnt_q <= asm_cnt_q + 3'h1;
            if (asm_cnt_q == 3'h7) begin
                asm_full_q <= 1'b1;
            end
        end
    end

    e3lapd_fifo #(
        .WIDTH (8),
        .DEPTH (`E3L_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_valid  (asm_full_q),
        .in_ready  (fifo_in_ready),
        .in_data   (asm_q),
        .out_valid (fifo_out_valid),
        .out_ready (frame_slot && enable),
        .out_data  (fifo_out_data)
    );

    // one octet per outbound frame into the chosen overhead byte
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            nr_ins_q  <= 1'b0;
            gc_ins_q  <= 1'b0;
            oh_byte_q <= `E3L_FLAG;
        end else begin
            nr_ins_q <= frame_slot && enable && txe3_q[`E3L_BIT_NR_SEL];
            gc_ins_q <= frame_slot && enable && !txe3_q[`E3L_BIT_NR_SEL];
            if (frame_slot) begin
                oh_byte_q <= fifo_out_valid ? fifo_out_data : `E3L_FLAG;
            end
        end
    end
endmodule

// *** sim/e3lapd_tx_checker.sv ***
// port assertions for the message transmitter
`timescale 1ns/1ps
module e3lapd_tx_checker (
    input wire        core_clk,    // clock
    input wire        reset_n,     // reset, active low
    input wire [15:0] cpu_addr,    // address
    input wire        cpu_wr,      // write strobe
    input wire        cpu_rd,      // read strobe
    input wire [7:0]  cpu_wdata,   // write data
    input wire [7:0]  cpu_rdata_q, // read data
    input wire        frame_slot,  // slot pulse
    input wire        nr_ins_q,    // nr strobe
    input wire        gc_ins_q,    // gc strobe
    input wire [7:0]  oh_byte_q    // overhead octet
);
    reg [7:0] cfg_q;
    reg       en_q;
    wire      ins = nr_ins_q | gc_ins_q;
    wire      mapped = cpu_addr == 16'h1100 || cpu_addr == 16'h1130 || cpu_addr == 16'h1133;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= 8'h00;
            en_q  <= 1'b0;
        end else if (cpu_wr) begin
            if (cpu_addr == 16'h1130) cfg_q <= cpu_wdata & 8'h17;
            if (cpu_addr == 16'h1133) en_q <= cpu_wdata[0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence slot_ins;
        frame_slot ##1 ins ##1 !ins;
    endsequence
    chk_slot_insert: assert property (frame_slot && en_q && $past(en_q) |-> slot_ins)
        else $error("no insertion after a frame slot");
    chk_ins_cause: assert property (ins |-> $past(frame_slot) && $past(en_q))
        else $error("insertion without slot or enable");
    chk_one_channel: assert property (!(nr_ins_q && gc_ins_q))
        else $error("both channel strobes high");
    chk_nr_select: assert property (nr_ins_q |-> $past(cfg_q[4]))
        else $error("nr strobe while gc selected");
    chk_gc_select: assert property (gc_ins_q |-> !$past(cfg_q[4]))
        else $error("gc strobe while nr selected");
    chk_byte_hold: assert property (!$past(frame_slot) |-> $stable(oh_byte_q))
        else $error("overhead octet moved between slots");
    chk_rd_unmapped: assert property (cpu_rd && !mapped && cpu_addr != 16'h11b0
        |=> cpu_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    chk_rd_cfg: assert property (cpu_rd && !cpu_wr && cpu_addr == 16'h1130
        |=> cpu_rdata_q == cfg_q)
        else $error("channel config readback wrong");
    chk_rd_stand: assert property (!$past(cpu_rd) |-> $stable(cpu_rdata_q))
        else $error("read data changed without a read");
    chk_reset_flag: assert property ($rose(reset_n) |-> oh_byte_q == 8'h7e)
        else $error("overhead octet not flag after reset");
endmodule
bind e3lapd_tx e3lapd_tx_checker e3lapd_tx_checker_inst (.core_clk(core_clk), .reset_n(reset_n),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata_q(cpu_rdata_q), .frame_slot(frame_slot), .nr_ins_q(nr_ins_q),
    .gc_ins_q(gc_ins_q), .oh_byte_q(oh_byte_q));

// *** sim/e3lapd_far.sv ***
// far-end model: makes frame slots and unpacks received messages
`timescale 1ns/1ps
module e3lapd_far #(parameter PERIOD = 16) (
    input  wire       core_clk,  // clock
    input  wire       reset_n,   // reset, active low
    input  wire       nr_ins_q,  // nr strobe
    input  wire       gc_ins_q,  // gc strobe
    input  wire [7:0] oh_byte_q, // overhead octet
    output reg        frame_slot // slot pulse
);
    reg [7:0] rx_msg [0:127];
    reg       bits [0:2047];
    integer   rx_len = 0, rx_cnt = 0, nr_cnt = 0, gc_cnt = 0, other_cnt = 0;
    integer   nb = 0, ones = 0, cyc = 0, i, j;
    initial frame_slot = 1'b0;
    always @(negedge core_clk) begin
        cyc = reset_n ? (cyc + 1) % PERIOD : 0;
        frame_slot <= reset_n && cyc == PERIOD - 1;
    end
    // bits arrive lsb first; stuffed zeros dropped, flags close frames
    always @(posedge core_clk) begin
        if (nr_ins_q || gc_ins_q) begin
            nr_cnt = nr_cnt + nr_ins_q;
            gc_cnt = gc_cnt + gc_ins_q;
            if (oh_byte_q !== 8'h7e) other_cnt = other_cnt + 1;
            for (i = 0; i < 8; i++) begin
                if (oh_byte_q[i]) begin
                    bits[nb] = 1'b1;
                    nb++;
                    ones++;
                end else if (ones == 6) begin
                    if (nb >= 39 && (nb - 7) % 8 == 0) begin
                        rx_len = (nb - 7) / 8;
                        for (j = 0; j < nb - 7; j++) rx_msg[j / 8][j % 8] = bits[j];
                        rx_cnt++;
                    end
                    nb = 0;
                    ones = 0;
                end else begin
                    if (ones != 5) bits[nb] = 1'b0;
                    if (ones != 5) nb++;
                    ones = 0;
                end
                if (nb > 2000) nb = 0;
            end
        end
    end
endmodule

// *** sim/tb_e3lapd_tx.sv ***
// self-checking bench for the message transmitter
`timescale 1ns/1ps
module tb_e3lapd_tx;
    reg         core_clk, reset_n, cpu_wr, cpu_rd;
    reg  [15:0] cpu_addr, crc;
    reg  [7:0]  cpu_wdata;
    reg  [7:0]  msg [0:127];
    wire [7:0]  cpu_rdata_q, oh_byte_q;
    wire        frame_slot, nr_ins_q, gc_ins_q;
    integer     fails = 0, check_count = 0, n0 = 0, k;
    e3lapd_tx #(.SEC_CYCLES(4000)) e3lapd_tx_inst (.core_clk(core_clk), .reset_n(reset_n),
        .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
        .cpu_rdata_q(cpu_rdata_q), .frame_slot(frame_slot), .nr_ins_q(nr_ins_q),
        .gc_ins_q(gc_ins_q), .oh_byte_q(oh_byte_q));
    e3lapd_far e3lapd_far_inst (.core_clk(core_clk), .reset_n(reset_n), .nr_ins_q(nr_ins_q),
        .gc_ins_q(gc_ins_q), .oh_byte_q(oh_byte_q), .frame_slot(frame_slot));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task test_done;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check(input [15:0] seen, input [15:0] exp, input [8*8-1:0] what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %0s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        @(negedge core_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge core_clk);
        cpu_wr = 1'b0;
    endtask
    task rd(input [15:0] a, input [7:0] e);
        @(negedge core_clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge core_clk);
        cpu_rd = 1'b0;
        check(cpu_rdata_q, e, "register");
    endtask
    task load(input integer len, input [7:0] first);
        integer p;
        msg[0] = 8'h3c;
        msg[1] = 8'h01;
        msg[2] = 8'h03;
        msg[3] = first;
        for (p = 1; p < len; p++) msg[p + 3] = (p % 3 == 0) ? 8'hff : 8'h7e ^ p[7:0];
        wr(16'h11b0, 8'h7e);
        for (p = 0; p < len + 3; p++) wr(16'h11b0, msg[p]);
    endtask
    task expect_msg(input integer len);
        integer w, a, b;
        for (w = 0; w < 9000 && e3lapd_far_inst.rx_cnt == n0; w++) @(negedge core_clk);
        check(e3lapd_far_inst.rx_cnt, n0 + 1, "count");
        n0 = n0 + 1;
        check(e3lapd_far_inst.rx_len, len + 5, "length");
        crc = 16'hffff;
        for (a = 0; a < len + 3; a++)
            for (b = 0; b < 8; b++)
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ msg[a][b]) ? 16'h1021 : 16'h0000);
        msg[len + 3] = ~crc[15:8];
        msg[len + 4] = ~crc[7:0];
        for (a = 0; a < len + 5; a++)
            check(e3lapd_far_inst.rx_msg[a], msg[a], "octet");
    endtask
    initial begin
        #700000;
        fails++;
        test_done;
    end
    initial begin
        reset_n = 1'b0;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        rd(16'h1100, 8'h00);
        rd(16'h1130, 8'h00);
        rd(16'h1133, 8'h00);
        rd(16'h1200, 8'h00);
        wr(16'h1100, 8'h04);
        rd(16'h1100, 8'h04);
        wr(16'h1130, 8'hff);
        rd(16'h1130, 8'h17);
        wr(16'h1130, 8'h00);
        repeat (100) @(negedge core_clk);
        check(e3lapd_far_inst.gc_cnt + e3lapd_far_inst.nr_cnt, 0, "disabled");
        wr(16'h1133, 8'h01);
        repeat (200) @(negedge core_clk);
        check(e3lapd_far_inst.other_cnt, 0, "idle");
        check(e3lapd_far_inst.nr_cnt, 0, "nr count");
        check(e3lapd_far_inst.gc_cnt > 9, 1, "gc count");
        load(76, 8'h38);
        repeat (300) @(negedge core_clk);
        rd(16'h1133, 8'h21);
        expect_msg(76);
        wr(16'h1133, 8'h00);
        wr(16'h1130, 8'h10);
        wr(16'h1133, 8'h03);
        k = e3lapd_far_inst.nr_cnt;
        load(82, 8'h3f);
        expect_msg(82);
        check(e3lapd_far_inst.nr_cnt > k, 1, "nr used");
        wr(16'h1133, 8'h80);
        load(10, 8'h32);
        wr(16'h1133, 8'h81);
        expect_msg(10);
        wr(16'h1133, 8'h00);
        load(76, 8'h34);
        wr(16'h1133, 8'h09);
        expect_msg(76);
        expect_msg(76);
        wr(16'h1133, 8'h00);
        // a slot taken on the disabling edge still lands one cycle later
        repeat (2) @(negedge core_clk);
        k = e3lapd_far_inst.nr_cnt;
        repeat (100) @(negedge core_clk);
        check(e3lapd_far_inst.nr_cnt, k, "stopped");
        test_done;
    end
endmodule
